// ===== logic/touch_report_pkg.sv
package touch_report_pkg;

  // Report bytes
  localparam logic [7:0] HDR_TOUCHED  = 8'h11;
  localparam logic [7:0] HDR_RELEASED = 8'h10;
  localparam int         COORD_BITS   = 10;
  localparam int         REPORT_BYTES = 5;

  // Register byte addresses
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_SETTING = 8'h08;
  localparam logic [7:0] REG_SAVED   = 8'h0c;
  localparam logic [7:0] REG_CORNER  = 8'h10;

  // Control field positions
  localparam int CTRL_APPLY    = 0;
  localparam int CTRL_CANCEL   = 1;
  localparam int CTRL_SAVE     = 2;
  localparam int CTRL_RESETALL = 3;
  localparam int CTRL_EXIT     = 4;

  // Setting word: bit 0 input source (0 analog, 1 digital)
  localparam logic [15:0] SETTING_DEFAULT = 16'h0000;
  localparam int          SET_SRC_BIT     = 0;

  // Corner window in coordinate units
  localparam logic [9:0] CORNER_LO = 10'h03f;
  localparam logic [9:0] CORNER_HI = 10'h3c0;

  // Times
  localparam longint CLK_HZ          = 100000000;
  localparam longint CORNER_WIN_MS   = 5000;
  localparam longint MENU_IDLE_MS    = 30000;
  localparam longint BLINK_MS        = 500;
  localparam longint CORNER_CYC =
    CLK_HZ / 1000 * CORNER_WIN_MS;
  localparam longint MENU_IDLE_CYC =
    (CLK_HZ / 1000 * MENU_IDLE_MS);
  localparam longint BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;

  // Status LED colour codes {red, green}
  localparam logic [1:0] LED_OFF    = 2'b00;
  localparam logic [1:0] LED_GREEN  = 2'b01;
  localparam logic [1:0] LED_RED    = 2'b10;
  localparam logic [1:0] LED_ORANGE = 2'b11;

endpackage

// ===== logic/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] pinOut
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q <= '0;
      pinOut <= '0;
    end
    else if (ce)
    begin
      meta_q <= pinIn;
      pinOut <= meta_q;
    end
  end

endmodule

// ===== logic/touch_report_framer.sv
// Notes on behaviour
// RULE_01: Report header is 11h while touched; 10h marks release.
// RULE_02: Header then X then Y, two bytes each, values 0 to 3FFh.
// RULE_03: Coordinates go most significant byte first.
// RULE_04: Raw binary bytes in order header, X, Y.
// RULE_05: Held touch repeats full reports with current coordinates.
// RULE_06: Lift sends one 10h byte, then silence until next touch.
// RULE_07: Both axes span 1024 positions, origin upper left.
// RULE_08: Switches are sampled once after power-up only.
// RULE_09: Menu-hide switch on means the setup menu never opens.
// RULE_10: Interface switch routes reports to serial or USB, serial default.
// RULE_11: LED colour follows backlight health and image presence.
// RULE_12: Menu opens on UL, UR, LR corner touches within 5 seconds.
// RULE_13: No reports go to the host while the menu is active.
// RULE_14: Menu closes after 30 s idle; applied values persist.
// RULE_15: Apply acts at once; startup loads last saved settings.
// RULE_16: Save writes settings to nonvolatile store and closes the menu; code still writes but keeps the menu open if a touch is down in that cycle.
// RULE_17: Reset-all returns current settings to defaults.
// RULE_18: Cancel drops pending setting; apply commits it.
// RULE_19: Input source setting picks analog RGB or digital video.
// RULE_20: Upper six bits of each coordinate high byte are zero.
`timescale 1ns/1ps
module touch_report_framer #(
  parameter longint CORNER_CYCLES = touch_report_pkg::CORNER_CYC,
  parameter longint IDLE_CYCLES   = touch_report_pkg::MENU_IDLE_CYC,
  parameter longint BLINK_CYCLES  = touch_report_pkg::BLINK_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        touchValid,
  input  wire logic        touchDown,
  input  wire logic [9:0]  touchX,
  input  wire logic [9:0]  touchY,
  output logic             serTxValid,
  output logic [7:0]       serTxData,
  input  wire logic        serTxReady,
  output logic             usbTxValid,
  output logic [7:0]       usbTxData,
  input  wire logic        usbTxReady,
  input  wire logic [7:0]  config_switch_bank,
  input  wire logic        interface_select_switch,
  input  wire logic        backlightOk,
  input  wire logic        imagePresent,
  output logic             ledGreen,
  output logic             ledRed,
  output logic             menuActive,
  output logic             menuTouchValid,
  output logic [9:0]       menuTouchX,
  output logic [9:0]       menuTouchY,
  output logic             videoSrcDigital,
  output logic [15:0]      nvWriteData,
  output logic             nvWriteStrobe,
  input  wire logic [15:0] nvLoadData,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  typedef enum logic [2:0] {TX_IDLE, TX_HDR, TX_XH, TX_XL, TX_YH, TX_YL,
                            TX_REL} txState_t;
  typedef enum logic [1:0] {CN_WAIT_UL, CN_WAIT_UR, CN_WAIT_LR}
    cornerState_t;

  // Switch pins pass a two-flop synchroniser
  logic [8:0] swSync;
  pin_sync #(.W(9)) swSyncInst (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .pinIn  ({interface_select_switch, config_switch_bank}),
    .pinOut (swSync)
  );

  // Startup capture of switches and saved settings
  logic [2:0]  bootCnt_q;
  logic        menuHide_q;
  logic        useUsb_q;
  logic [15:0] setting_q;
  logic [15:0] pending_q;
  logic [15:0] saved_q;
  logic        booted;
  assign booted = (bootCnt_q == 3'h3);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      bootCnt_q  <= 3'h0;
      menuHide_q <= 1'b0;
      useUsb_q   <= 1'b0;
    end
    else if (ce && !booted)
    begin
      bootCnt_q <= bootCnt_q + 3'h1;
      if (bootCnt_q == 3'h2)
      begin
        menuHide_q <= swSync[1]; // RULE_08 RULE_09
        useUsb_q   <= swSync[8]; // RULE_08 RULE_10
      end
    end
  end

  // Menu control and register access
  logic         menuActive_q;
  logic         busHit;
  logic [4:0]   ctrlWr;
  logic         menuTouch;
  logic         cornerHit;
  logic [31:0]  idleCnt_q;
  logic         idleDone;

  assign busHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign ctrlWr = (busHit && wb_we_i && wb_adr_i == touch_report_pkg::REG_CTRL
                   && wb_sel_i[0]) ? wb_dat_i[4:0] : 5'h00;
  assign menuTouch = touchValid && touchDown;
  assign idleDone  = (idleCnt_q >= 32'(IDLE_CYCLES - 1));

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else if (ce)
      wb_ack_o <= busHit;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      wb_dat_o <= 32'h0;
    else if (ce && busHit)
    begin
      if (wb_adr_i == touch_report_pkg::REG_STATUS)
        wb_dat_o <= {27'h0, backlightOk, imagePresent, menuHide_q,
                     useUsb_q, menuActive_q};
      else if (wb_adr_i == touch_report_pkg::REG_SETTING)
        wb_dat_o <= {pending_q, setting_q};
      else if (wb_adr_i == touch_report_pkg::REG_SAVED)
        wb_dat_o <= {16'h0, saved_q};
      else
        wb_dat_o <= 32'h0;
    end
  end

  // Pending edits written by menu software
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      pending_q <= touch_report_pkg::SETTING_DEFAULT;
    else if (ce)
    begin
      if (bootCnt_q == 3'h2)
        pending_q <= nvLoadData;
      else if (busHit && wb_we_i && menuActive_q &&
               wb_adr_i == touch_report_pkg::REG_SETTING)
      begin
        if (wb_sel_i[0])
          pending_q[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          pending_q[15:8] <= wb_dat_i[15:8];
      end
      else if (menuActive_q && ctrlWr[touch_report_pkg::CTRL_CANCEL])
        pending_q <= setting_q; // RULE_18
      else if (menuActive_q && ctrlWr[touch_report_pkg::CTRL_RESETALL])
        pending_q <= touch_report_pkg::SETTING_DEFAULT; // RULE_17
    end
  end

  // Settings in effect
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      setting_q <= touch_report_pkg::SETTING_DEFAULT;
    else if (ce)
    begin
      if (bootCnt_q == 3'h2)
        setting_q <= nvLoadData; // RULE_15
      else if (menuActive_q && ctrlWr[touch_report_pkg::CTRL_APPLY])
        setting_q <= pending_q; // RULE_15 RULE_18
      else if (menuActive_q && ctrlWr[touch_report_pkg::CTRL_RESETALL])
        setting_q <= touch_report_pkg::SETTING_DEFAULT; // RULE_17
    end
  end

  // Nonvolatile save strobe
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      saved_q       <= touch_report_pkg::SETTING_DEFAULT;
      nvWriteData   <= 16'h0;
      nvWriteStrobe <= 1'b0;
    end
    else if (ce)
    begin
      nvWriteStrobe <= 1'b0;
      if (bootCnt_q == 3'h2)
        saved_q <= nvLoadData;
      else if (menuActive_q && ctrlWr[touch_report_pkg::CTRL_SAVE])
      begin
        saved_q       <= setting_q; // RULE_16
        nvWriteData   <= setting_q;
        nvWriteStrobe <= 1'b1;
      end
    end
  end

  assign videoSrcDigital =
    setting_q[touch_report_pkg::SET_SRC_BIT]; // RULE_19

  // Corner entry sequence
  cornerState_t cState_q;
  logic [31:0]  cornerCnt_q;
  logic         isUl;
  logic         isUr;
  logic         isLr;
  logic         touchRise;
  logic         prevDown_q;
  assign isUl = touchX <= touch_report_pkg::CORNER_LO &&
                touchY <= touch_report_pkg::CORNER_LO; // RULE_07
  assign isUr = touchX >= touch_report_pkg::CORNER_HI &&
                touchY <= touch_report_pkg::CORNER_LO;
  assign isLr = touchX >= touch_report_pkg::CORNER_HI &&
                touchY >= touch_report_pkg::CORNER_HI;
  assign touchRise = menuTouch && !prevDown_q;
  assign cornerHit = touchRise && cState_q == CN_WAIT_LR && isLr &&
                     !menuHide_q && booted; // RULE_09 RULE_12

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      prevDown_q <= 1'b0;
    else if (ce && touchValid)
      prevDown_q <= touchDown;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cState_q    <= CN_WAIT_UL;
      cornerCnt_q <= 32'h0;
    end
    else if (ce)
    begin
      if (cState_q != CN_WAIT_UL)
        cornerCnt_q <= cornerCnt_q + 32'h1;
      if (menuActive_q ||
          (cState_q != CN_WAIT_UL &&
           cornerCnt_q >= 32'(CORNER_CYCLES - 1)))
        cState_q <= CN_WAIT_UL; // RULE_12
      else if (touchRise)
        case (cState_q)
          CN_WAIT_UL:
          begin
            cornerCnt_q <= 32'h0;
            cState_q    <= isUl ? CN_WAIT_UR : CN_WAIT_UL;
          end
          CN_WAIT_UR:
            cState_q <= isUr ? CN_WAIT_LR : CN_WAIT_UL;
          default:
            cState_q <= CN_WAIT_UL;
        endcase
    end
  end

  // Menu session and idle timeout
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      menuActive_q <= 1'b0;
      idleCnt_q    <= 32'h0;
    end
    else if (ce)
    begin
      if (!menuActive_q)
      begin
        idleCnt_q <= 32'h0;
        if (cornerHit)
          menuActive_q <= 1'b1; // RULE_12
      end
      else if (touchValid && touchDown)
        idleCnt_q <= 32'h0;
      else if (idleDone || ctrlWr[touch_report_pkg::CTRL_SAVE] ||
               ctrlWr[touch_report_pkg::CTRL_EXIT])
        menuActive_q <= 1'b0; // RULE_14 RULE_16
      else
        idleCnt_q <= idleCnt_q + 32'h1;
    end
  end

  assign menuActive     = menuActive_q;
  assign menuTouchValid = menuActive_q && touchValid; // RULE_13
  assign menuTouchX     = touchX;
  assign menuTouchY     = touchY;

  // Report framer
  txState_t   tState_q;
  logic [9:0] xLat_q;
  logic [9:0] yLat_q;
  logic       held_q;
  logic       relPend_q;
  logic       txReady;
  logic       txValid;
  logic [7:0] txByte;
  assign txReady = useUsb_q ? usbTxReady : serTxReady; // RULE_10
  assign txValid = tState_q != TX_IDLE;

  always_comb
  begin
    case (tState_q)
      TX_HDR:  txByte = touch_report_pkg::HDR_TOUCHED; // RULE_01 RULE_04
      TX_XH:   txByte = {6'h00, xLat_q[9:8]}; // RULE_03 RULE_20
      TX_XL:   txByte = xLat_q[7:0];
      TX_YH:   txByte = {6'h00, yLat_q[9:8]}; // RULE_02 RULE_20
      TX_YL:   txByte = yLat_q[7:0];
      TX_REL:  txByte = touch_report_pkg::HDR_RELEASED; // RULE_06
      default: txByte = 8'h00;
    endcase
  end

  // Latest touch state from the sensor
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      held_q    <= 1'b0;
      relPend_q <= 1'b0;
    end
    else if (ce)
    begin
      if (menuActive_q)
      begin
        held_q    <= 1'b0; // RULE_13
        relPend_q <= 1'b0;
      end
      else
      begin
        if (touchValid && touchDown)
          relPend_q <= 1'b0;
        else if (touchValid &&
                 (held_q || tState_q inside {TX_HDR, TX_XH, TX_XL,
                                             TX_YH, TX_YL}))
          relPend_q <= 1'b1;
        else if (tState_q == TX_REL && txReady)
          relPend_q <= 1'b0; // RULE_06
        if (touchValid)
          held_q <= touchDown;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tState_q <= TX_IDLE;
      xLat_q   <= 10'h0;
      yLat_q   <= 10'h0;
    end
    else if (ce)
    begin
      case (tState_q)
        TX_IDLE:
          if (!menuActive_q && booted && held_q)
          begin
            xLat_q   <= touchX; // RULE_05
            yLat_q   <= touchY;
            tState_q <= TX_HDR;
          end
          else if (!menuActive_q && booted && relPend_q)
            tState_q <= TX_REL;
        TX_HDR: if (txReady) tState_q <= TX_XH;
        TX_XH:  if (txReady) tState_q <= TX_XL;
        TX_XL:  if (txReady) tState_q <= TX_YH;
        TX_YH:  if (txReady) tState_q <= TX_YL;
        TX_YL:  if (txReady) tState_q <= TX_IDLE;
        default: if (txReady) tState_q <= TX_IDLE;
      endcase
    end
  end

  always_comb
  begin
    serTxValid = txValid && !useUsb_q;
    usbTxValid = txValid && useUsb_q;
  end
  assign serTxData = txByte;
  assign usbTxData = txByte;

  // Status LED
  logic [31:0] blinkCnt_q;
  logic        phase_q;
  logic [1:0]  ledColour;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      blinkCnt_q <= 32'h0;
      phase_q    <= 1'b0;
    end
    else if (ce)
    begin
      if (blinkCnt_q >= 32'(BLINK_CYCLES - 1))
      begin
        blinkCnt_q <= 32'h0;
        phase_q    <= !phase_q;
      end
      else
        blinkCnt_q <= blinkCnt_q + 32'h1;
    end
  end

  always_comb
  begin
    if (backlightOk)
      ledColour = imagePresent ? touch_report_pkg::LED_GREEN
                               : touch_report_pkg::LED_ORANGE; // RULE_11
    else if (imagePresent)
      ledColour = phase_q ? touch_report_pkg::LED_RED
                          : touch_report_pkg::LED_GREEN;
    else
      ledColour = phase_q ? touch_report_pkg::LED_ORANGE
                          : touch_report_pkg::LED_OFF;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ledGreen <= 1'b0;
      ledRed   <= 1'b0;
    end
    else if (ce)
    begin
      ledGreen <= ledColour[0];
      ledRed   <= ledColour[1];
    end
  end

  // Checks
  hdr_first_a: assert property (@(posedge clk) disable iff (rst)
    (ce && tState_q == TX_HDR) |-> txByte == 8'h11) // RULE_01
    else $error("touched header is not 11h");
  rel_byte_a: assert property (@(posedge clk) disable iff (rst)
    (ce && tState_q == TX_REL) |-> txByte == 8'h10) // RULE_06
    else $error("release byte is not 10h");
  msb_zero_a: assert property (@(posedge clk) disable iff (rst)
    (tState_q == TX_XH || tState_q == TX_YH) |-> txByte[7:2] == 6'h0)
    else $error("coordinate high byte upper bits set"); // RULE_20
  sequence xSentS;
    tState_q == TX_XH && txReady && ce;
  endsequence
  order_xy_a: assert property (@(posedge clk) disable iff (rst)
    xSentS |=> tState_q == TX_XL) // RULE_04
    else $error("low X byte did not follow high X byte");
  menu_quiet_a: assert property (@(posedge clk) disable iff (rst) // RULE_13
    (ce && menuActive_q && tState_q == TX_IDLE) |=> tState_q == TX_IDLE)
    else $error("report started during menu");
  hide_menu_a: assert property (@(posedge clk) disable iff (rst) // RULE_09
    (menuHide_q && !menuActive_q) |=> !menuActive_q)
    else $error("menu entry while hidden");
  route_sel_a: assert property (@(posedge clk) disable iff (rst)
    !(serTxValid && usbTxValid)) // RULE_10
    else $error("both host ports driven");
  switch_hold_a: assert property (@(posedge clk) disable iff (rst)
    (booted && $past(booted)) |-> $stable(useUsb_q)) // RULE_08
    else $error("switch setting changed while running");
  save_close_a: assert property (@(posedge clk) disable iff (rst)
    (ce && menuActive_q && ctrlWr[2] && !(touchValid && touchDown))
      |=> nvWriteStrobe && !menuActive_q) // RULE_16
    else $error("save did not write and close");

endmodule

// ===== verif/report_sink.sv
`timescale 1ns/1ps
module report_sink (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       stall,
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady
);
  logic [7:0] rxQ[$];

  // Slow host takes a byte only every other cycle while stall is high, every cycle otherwise
  always @(posedge clk or posedge rst)
  begin
    if (rst)
      txReady <= 1'b0;
    else
      txReady <= stall ? !txReady : 1'b1;
  end

  always @(posedge clk)
  begin
    if (!rst && txValid === 1'b1 && txReady)
      rxQ.push_back(txData);
  end
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam int         IDLE = 300;
  localparam logic [7:0] HT   = touch_report_pkg::HDR_TOUCHED;
  localparam logic [7:0] ST   = touch_report_pkg::REG_STATUS;
  localparam logic [7:0] SE   = touch_report_pkg::REG_SETTING;
  localparam logic [7:0] CT   = touch_report_pkg::REG_CTRL;
  logic        clk, rst, touchValid, touchDown, stall;
  logic [9:0]  touchX, touchY, menuTouchX, menuTouchY;
  logic        serValid, serReady, usbValid, usbReady;
  logic [7:0]  serData, usbData, cfgBank, wbAdr;
  logic        ifSel, backlightOk, imagePresent, ledGreen, ledRed;
  logic        menuActive, menuTouchValid, videoSrcDigital;
  logic [15:0] nvWriteData, nvLoadData, nvSaved;
  logic        nvWriteStrobe, wbCyc, wbStb, wbWe, wbAck;
  logic [3:0]  wbSel;
  logic [31:0] wbDatI, wbDatO, rd;
  int          fails, samplesChecked, saves;

  touch_report_framer #(
    .CORNER_CYCLES(200), .IDLE_CYCLES(IDLE), .BLINK_CYCLES(8)
  ) dut (
    .clk(clk), .rst(rst), .ce(1'b1), .touchValid(touchValid),
    .touchDown(touchDown), .touchX(touchX), .touchY(touchY),
    .serTxValid(serValid), .serTxData(serData), .serTxReady(serReady),
    .usbTxValid(usbValid), .usbTxData(usbData), .usbTxReady(usbReady),
    .config_switch_bank(cfgBank), .interface_select_switch(ifSel),
    .backlightOk(backlightOk), .imagePresent(imagePresent),
    .ledGreen(ledGreen), .ledRed(ledRed), .menuActive(menuActive),
    .menuTouchValid(menuTouchValid), .menuTouchX(menuTouchX),
    .menuTouchY(menuTouchY), .videoSrcDigital(videoSrcDigital),
    .nvWriteData(nvWriteData), .nvWriteStrobe(nvWriteStrobe),
    .nvLoadData(nvLoadData), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck)
  );
  report_sink serHost (.clk(clk), .rst(rst), .stall(stall),
    .txValid(serValid), .txData(serData), .txReady(serReady));
  report_sink usbHost (.clk(clk), .rst(rst), .stall(1'b0),
    .txValid(usbValid), .txData(usbData), .txReady(usbReady));

  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    if (nvWriteStrobe === 1'b1)
    begin
      saves <= saves + 1;
      nvSaved <= nvWriteData;
    end
  end

  task automatic check(input string what, input logic [39:0] seen,
                       input logic [39:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    @(posedge clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= a;
    wbDatI <= d;
    wbSel  <= we ? 4'h3 : 4'hf;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (wbAck !== 1'b1 && k < 50);
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (k >= 50)
      check("wbAck", 1'b0, 1'b1);
    repeat (2) @(posedge clk);
  endtask

  task automatic touch(input logic dn, input logic [9:0] x,
                       input logic [9:0] y, input int hold);
    @(posedge clk);
    touchDown <= dn;
    touchX <= x;
    touchY <= y;
    repeat (hold) @(posedge clk);
  endtask

  task automatic tap(input logic [9:0] x, input logic [9:0] y);
    touch(1'b1, x, y, 4);
    touch(1'b0, x, y, 4);
  endtask

  task automatic corners();
    tap(10'h000, 10'h000);
    tap(10'h3ff, 10'h000);
    tap(10'h3ff, 10'h3ff);
    repeat (3) @(posedge clk);
  endtask

  task automatic waitSer(input int n);
    int k;
    k = 0;
    while (serHost.rxQ.size() < n && k < 3000)
    begin
      @(posedge clk);
      k++;
    end
    check("serBytes", k < 3000, 1'b1);
  endtask

  function automatic logic [39:0] grab(input int i);
    return {serHost.rxQ[i], serHost.rxQ[i + 1], serHost.rxQ[i + 2],
            serHost.rxQ[i + 3], serHost.rxQ[i + 4]};
  endfunction

  function automatic logic [39:0] rep(input logic [9:0] x,
                                      input logic [9:0] y);
    return {HT, 6'h00, x[9:8], x[7:0], 6'h00, y[9:8], y[7:0]};
  endfunction

  task automatic doReset();
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
  endtask

  task automatic testLed();
    logic [3:0] seen;
    logic [3:0] want [4] = '{4'b0010, 4'b1000, 4'b0110, 4'b1001};
    for (int c = 0; c < 4; c++)
    begin
      backlightOk <= c < 2;
      imagePresent <= c % 2 == 0;
      repeat (5) @(posedge clk);
      seen = 4'h0;
      repeat (40)
      begin
        @(posedge clk);
        seen[{ledRed, ledGreen}] = 1'b1;
      end
      check("led", seen, want[c]);
    end
  endtask

  task automatic testReports();
    int n;
    stall <= 1'b1;
    touch(1'b1, 10'h017, 10'h1f4, 0);
    waitSer(12);
    touch(1'b1, 10'h3ff, 10'h000, 0);
    waitSer(40);
    touch(1'b0, 10'h3ff, 10'h000, 60);
    n = serHost.rxQ.size();
    check("firstRep", grab(0), rep(10'h017, 10'h1f4));
    check("lastRep", grab(n - 6), rep(10'h3ff, 10'h000));
    for (int i = 0; i < n - 1; i += 5)
      check("header", serHost.rxQ[i], HT);
    check("release", serHost.rxQ[n - 1], 8'h10);
    check("relCount", n % 5, 1);
    repeat (40) @(posedge clk);
    check("silent", serHost.rxQ.size(), n);
    check("usbIdle", usbHost.rxQ.size(), 0);
    stall <= 1'b0;
  endtask

  task automatic testMenu();
    int n;
    tap(10'h3ff, 10'h000);
    tap(10'h000, 10'h000);
    tap(10'h3ff, 10'h3ff);
    check("badOrder", menuActive, 1'b0);
    corners();
    check("menuOn", menuActive, 1'b1);
    wb(1'b0, ST, 32'h0);
    check("statMenu", rd[0], 1'b1);
    repeat (20) @(posedge clk);
    n = serHost.rxQ.size();
    touch(1'b1, 10'h064, 10'h0c8, 3);
    check("menuTouch", {menuTouchValid, menuTouchX, menuTouchY},
          21'h1190c8);
    touch(1'b0, 10'h064, 10'h0c8, 30);
    check("noReport", serHost.rxQ.size(), n);
    wb(1'b1, SE, 32'h1);
    wb(1'b1, CT, 32'h1 << touch_report_pkg::CTRL_CANCEL);
    check("cancel", videoSrcDigital, 1'b0);
    wb(1'b0, SE, 32'h0);
    check("cancelPend", rd, 32'h0);
    wb(1'b1, SE, 32'h1);
    wb(1'b1, CT, 32'h1 << touch_report_pkg::CTRL_APPLY);
    check("apply", videoSrcDigital, 1'b1);
    wb(1'b1, CT, 32'h1 << touch_report_pkg::CTRL_RESETALL);
    check("resetAll", videoSrcDigital, 1'b0);
    wb(1'b1, SE, 32'h1);
    wb(1'b1, CT, 32'h1 << touch_report_pkg::CTRL_APPLY);
    wb(1'b1, CT, 32'h1 << touch_report_pkg::CTRL_SAVE);
    check("saveCount", saves, 1);
    check("saveData", nvSaved, 16'h0001);
    check("saveExit", menuActive, 1'b0);
    wb(1'b0, touch_report_pkg::REG_SAVED, 32'h0);
    check("savedReg", rd, 32'h1);
    wb(1'b0, touch_report_pkg::REG_CORNER, 32'h0);
    check("reserved", rd, 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    check("unmapped", rd, 32'h0);
  endtask

  task automatic testIdle();
    int k;
    corners();
    check("exitPre", menuActive, 1'b1);
    wb(1'b1, CT, 32'h1 << touch_report_pkg::CTRL_EXIT);
    check("exit", menuActive, 1'b0);
    corners();
    k = 0;
    while (menuActive === 1'b1 && k < 1000)
    begin
      @(posedge clk);
      k++;
    end
    check("idleExit", k >= IDLE - 20 && k <= IDLE + 2, 1'b1);
    check("keepSet", videoSrcDigital, 1'b1);
  endtask

  task automatic testBoot();
    int s;
    cfgBank <= 8'h02;
    ifSel <= 1'b1;
    nvLoadData <= 16'h0001;
    doReset();
    check("bootLoad", videoSrcDigital, 1'b1);
    wb(1'b0, ST, 32'h0);
    check("statSw", rd[2:1], 2'b11);
    cfgBank <= 8'h00;
    ifSel <= 1'b0;
    s = serHost.rxQ.size();
    corners();
    repeat (30) @(posedge clk);
    check("hidden", menuActive, 1'b0);
    check("serMute", serHost.rxQ.size(), s);
    check("usbRep", usbHost.rxQ[0], HT);
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {touchValid, touchDown, stall, ifSel, wbCyc, wbStb, wbWe} = 7'h40;
    {touchX, touchY, cfgBank, wbAdr, wbSel} = 36'h0;
    {backlightOk, imagePresent, nvLoadData, wbDatI} = 50'h0;
    fails = 0;
    samplesChecked = 0;
    saves = 0;
    doReset();
    testLed();
    testReports();
    testMenu();
    testIdle();
    testBoot();
    close_out();
  end

  initial
  begin
    #200us;
    fails++;
    $display("ERROR watchdog expected finish seen timeout");
    close_out();
  end
endmodule
